/* include/hlf_consts.svh */
// Purpose: named constants of the host link block
// Assumes: 40 MHz clock
// Notes: bus command codes are the 7-bit message values
`ifndef HLF_CONSTS_SVH
`define HLF_CONSTS_SVH
// ==========================================
// clock and timing
`define CLK_HZ 40000000
`define CLK_NS 25
`define DIV_OF(b) ((`CLK_HZ + (b) / 2) / (b))
`define DIV_W 13
`define T1_NS 2000
`define T1_CYC ((`T1_NS + `CLK_NS - 1) / `CLK_NS)
`define T1_W 7
// ==========================================
// serial framing and flow control
`define FRAME_BITS 4'hA
`define STOP_BIT 4'h9
`define CHAR_XOFF 8'h13
`define CHAR_XON 8'h11
`define RXBUF_CAP 9'h100
`define XOFF_LVL (`RXBUF_CAP - `RXBUF_CAP / 9'h004)
`define XON_LVL (`RXBUF_CAP / 9'h004)
// ==========================================
// bus messages
`define CMD_GTL 7'h01
`define CMD_SDC 7'h04
`define CMD_PPC 7'h05
`define CMD_GET 7'h08
`define CMD_LLO 7'h11
`define CMD_DCL 7'h14
`define CMD_PPU 7'h15
`define CMD_SPE 7'h18
`define CMD_SPD 7'h19
`define GRP_LAG 2'h1
`define GRP_TAG 2'h2
`define ADDR_UN 5'h1F
`endif

/* include/hlf_pkg.sv */
// Purpose: types of the host link block
// Assumes: bus line fields are true when the message is asserted
// Notes: none
package hlf_pkg;
   // ==========================================
   // modes and states
   typedef enum logic [1:0] {
      BAUD_9600 = 2'h0,
      BAUD_19200 = 2'h1,
      BAUD_38400 = 2'h3,
      BAUD_57600 = 2'h2
   } hlf_baud_t;
   typedef enum logic [1:0] {
      AH_RDY = 2'h0,
      AH_GOT = 2'h1,
      AH_WAIT = 2'h3
   } hlf_ah_t;
   typedef enum logic [1:0] {
      SH_IDLE = 2'h0,
      SH_WAIT = 2'h1,
      SH_DAV = 2'h3,
      SH_END = 2'h2
   } hlf_sh_t;
   // ==========================================
   // bus carriers
   typedef struct packed {
      logic [7:0] dio;
      logic dav, nrfd, ndac, atn, eoi, ifc, ren;
   } hlf_bus_in_t;
   typedef struct packed {
      logic [7:0] dio;
      logic dio_oe;
      logic dav, dav_oe, nrfd, nrfd_oe, ndac, ndac_oe;
      logic eoi, eoi_oe, srq, srq_oe;
   } hlf_bus_out_t;
   // ==========================================
   // module state
   typedef struct packed {
      logic [12:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [8:0] tx_sh;
      logic tx_busy, txd;
      logic [12:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_busy, rx_valid;
      logic [7:0] rx_data;
   } hlf_uart_t;
   typedef struct packed {
      logic u_start;
      logic [7:0] u_data;
      logic tx_ready, tx_held, host_paused, pend_xoff, pend_xon;
      logic rx_valid;
      logic [7:0] rx_data;
      logic talker, listener, spoll, remote, lockout;
      logic dev_clear, trigger, rqs_sent;
      hlf_ah_t ah;
      hlf_sh_t sh;
      logic [6:0] sh_cnt;
      logic sh_sp, bus_tx_ready, bus_rx_valid, bus_rx_eoi;
      logic [7:0] bus_rx_data;
      hlf_bus_out_t out;
   } hlf_main_t;
endpackage

/* verilog/hlf_uart.sv */
// Purpose: one 8N1 character engine, transmit and receive
// Assumes: i_div is the bit period in clocks, held stable
// Notes: a start request while busy is ignored
`timescale 1ns/100ps
`include "hlf_consts.svh"
module hlf_uart import hlf_pkg::*; (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic [12:0] i_div,
   input wire logic i_rxd,
   input wire logic i_tx_start,
   input wire logic [7:0] i_tx_data,
   output logic o_txd,
   output logic o_tx_busy,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data
);
   hlf_uart_t s, next_s;

   // ==========================================
   // transmitter and receiver
   always_comb begin
      next_s = s;
      next_s.rx_valid = 1'b0;
      if (!s.tx_busy) begin
         if (i_tx_start) begin
            next_s.tx_busy = 1'b1;
            next_s.tx_bit = 4'h0;
            next_s.tx_cnt = i_div - 13'h0001;
            next_s.tx_sh = {1'b1, i_tx_data};
            next_s.txd = 1'b0;
         end
      end else if (s.tx_cnt != 13'h0000) begin
         next_s.tx_cnt = s.tx_cnt - 13'h0001;
      end else begin
         next_s.tx_cnt = i_div - 13'h0001;
         next_s.tx_bit = s.tx_bit + 4'h1;
         next_s.txd = s.tx_sh[0];
         next_s.tx_sh = {1'b1, s.tx_sh[8:1]};
         if (s.tx_bit + 4'h1 == `FRAME_BITS) begin
            next_s.tx_busy = 1'b0;
            next_s.txd = 1'b1;
         end
      end
      // receiver samples each bit at its middle
      if (!s.rx_busy) begin
         if (!i_rxd) begin
            next_s.rx_busy = 1'b1;
            next_s.rx_bit = 4'h0;
            next_s.rx_cnt = {1'b0, i_div[12:1]};
         end
      end else if (s.rx_cnt != 13'h0000) begin
         next_s.rx_cnt = s.rx_cnt - 13'h0001;
      end else begin
         next_s.rx_cnt = i_div - 13'h0001;
         next_s.rx_bit = s.rx_bit + 4'h1;
         if (s.rx_bit == 4'h0) begin
            next_s.rx_busy = !i_rxd;
         end else if (s.rx_bit != `STOP_BIT) begin
            next_s.rx_sh = {i_rxd, s.rx_sh[7:1]};
         end else begin
            // a character with a bad stop bit is dropped
            next_s.rx_busy = 1'b0;
            next_s.rx_valid = i_rxd;
            if (i_rxd) begin
               next_s.rx_data = s.rx_sh;
            end
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s <= '0;
         s.txd <= 1'b1;
      end else if (i_ce) begin
         s <= next_s;
      end
   end

   assign o_txd = s.txd;
   assign o_tx_busy = s.tx_busy;
   assign o_rx_valid = s.rx_valid;
   assign o_rx_data = s.rx_data;
endmodule

/* verilog/hlf_link.sv */
// Purpose: serial flow control and parallel bus interface functions
// Assumes: bus fields true when asserted; inputs synchronous
// Notes: text bytes pass through unchanged
// ==========================================
// Summary of operation
// - send 13H when buffer above 75%
// - after pausing, send 11H below 25%
// - received 13H halts our transmission
// - received 11H resumes pending transmission
// - full source handshake for sending bytes
// - full acceptor handshake for receiving bytes
// - talker once addressed to talk
// - serial poll returns the status byte
// - no talk-only mode
// - own listen address ends talker state
// - listener once addressed to listen
// - no listen-only mode
// - own talk address ends listener state
// - service request when attention needed
// - remote, local and lockout handling
// - parallel poll is never answered
// - universal and selected device clear
// - group trigger while addressed listener
// - no controller functions at all
// - text is passed as ASCII bytes
// - four selectable baud rates
// - full duplex start/stop framing
`timescale 1ns/100ps
`include "hlf_consts.svh"
module hlf_link import hlf_pkg::*; #(
   parameter int P_DIV_9600 = `DIV_OF(9600)
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic i_rxd,
   output logic o_txd,
   input wire hlf_baud_t i_baud,
   input wire logic i_flow_en,
   input wire logic [8:0] i_rx_level,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_ready,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   output logic o_tx_held,
   output logic o_host_paused,
   input wire logic [4:0] i_my_addr,
   input wire hlf_bus_in_t i_bus,
   output hlf_bus_out_t o_bus,
   input wire logic [7:0] i_stb,
   input wire logic i_srq_req,
   input wire logic i_rtl,
   input wire logic i_bus_tx_valid,
   input wire logic [7:0] i_bus_tx_data,
   input wire logic i_bus_tx_eoi,
   output logic o_bus_tx_ready,
   output logic o_bus_rx_valid,
   output logic [7:0] o_bus_rx_data,
   output logic o_bus_rx_eoi,
   output logic o_talker,
   output logic o_listener,
   output logic o_spoll,
   output logic o_remote,
   output logic o_lockout,
   output logic o_dev_clear,
   output logic o_trigger
);
   hlf_main_t s, next_s;
   logic [12:0] div;
   logic u_busy, u_rx_valid;
   logic [7:0] u_rx_data;
   logic idle, act;
   logic [6:0] cmd;

   // ==========================================
   // serial character engine
   always_comb begin
      case (i_baud)
         BAUD_9600: div = 13'(P_DIV_9600);
         BAUD_19200: div = 13'(`DIV_OF(19200));
         BAUD_38400: div = 13'(`DIV_OF(38400));
         default: div = 13'(`DIV_OF(57600));
      endcase
   end

   hlf_uart u_uart (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_ce(i_ce),
      .i_div(div),
      .i_rxd(i_rxd),
      .i_tx_start(s.u_start),
      .i_tx_data(s.u_data),
      .o_txd(o_txd),
      .o_tx_busy(u_busy),
      .o_rx_valid(u_rx_valid),
      .o_rx_data(u_rx_data)
   );

   assign idle = !u_busy && !s.u_start;
   assign act = i_bus.atn || s.listener;
   assign cmd = i_bus.dio[6:0];

   // ==========================================
   // next state
   always_comb begin
      next_s = s;
      next_s.u_start = 1'b0;
      next_s.rx_valid = 1'b0;
      next_s.dev_clear = 1'b0;
      next_s.trigger = 1'b0;
      next_s.bus_tx_ready = 1'b0;
      next_s.bus_rx_valid = 1'b0;

      // ---- serial receive path
      if (u_rx_valid) begin
         if (i_flow_en && u_rx_data == `CHAR_XOFF) begin
            next_s.tx_held = 1'b1;
         end else if (i_flow_en && u_rx_data == `CHAR_XON) begin
            next_s.tx_held = 1'b0;
         end else begin
            next_s.rx_valid = 1'b1;
            next_s.rx_data = u_rx_data;
         end
      end

      // ---- throttling the host by buffer level
      if (i_flow_en) begin
         if (!s.host_paused && i_rx_level > `XOFF_LVL) begin
            next_s.host_paused = 1'b1;
            next_s.pend_xoff = 1'b1;
            next_s.pend_xon = 1'b0;
         end else if (s.host_paused && i_rx_level < `XON_LVL) begin
            next_s.host_paused = 1'b0;
            next_s.pend_xon = 1'b1;
            next_s.pend_xoff = 1'b0;
         end
      end

      // ---- serial transmit: flow codes go ahead of data
      if (idle && s.pend_xoff) begin
         next_s.u_start = 1'b1;
         next_s.u_data = `CHAR_XOFF;
         next_s.pend_xoff = 1'b0;
      end else if (idle && s.pend_xon) begin
         next_s.u_start = 1'b1;
         next_s.u_data = `CHAR_XON;
         next_s.pend_xon = 1'b0;
      end else if (s.tx_ready && i_tx_valid) begin
         next_s.u_start = 1'b1;
         next_s.u_data = i_tx_data;
      end

      if (!i_flow_en) begin
         next_s.tx_held = 1'b0;
         next_s.host_paused = 1'b0;
         next_s.pend_xoff = 1'b0;
         next_s.pend_xon = 1'b0;
      end
      // held data waits; a character already started still completes
      next_s.tx_ready = !next_s.tx_held && !next_s.pend_xoff && !next_s.pend_xon
         && !next_s.u_start && !s.u_start && !u_busy;

      // ---- acceptor handshake, commands and listener data
      case (s.ah)
         AH_RDY: begin
            if (act && i_bus.dav) begin
               next_s.ah = AH_GOT;
               if (i_bus.atn) begin
                  if (cmd[6:5] == `GRP_LAG) begin
                     if (cmd[4:0] == i_my_addr) begin
                        next_s.listener = 1'b1;
                        next_s.talker = 1'b0;
                        next_s.remote = i_bus.ren;
                     end else if (cmd[4:0] == `ADDR_UN) begin
                        next_s.listener = 1'b0;
                     end
                  end else if (cmd[6:5] == `GRP_TAG) begin
                     // any other talk address also unaddresses us
                     next_s.talker = cmd[4:0] == i_my_addr;
                     if (cmd[4:0] == i_my_addr) begin
                        next_s.listener = 1'b0;
                     end
                  end else if (cmd == `CMD_DCL) begin
                     next_s.dev_clear = 1'b1;
                  end else if (cmd == `CMD_SDC) begin
                     next_s.dev_clear = s.listener;
                  end else if (cmd == `CMD_GET) begin
                     next_s.trigger = s.listener;
                  end else if (cmd == `CMD_LLO) begin
                     next_s.lockout = 1'b1;
                  end else if (cmd == `CMD_GTL) begin
                     if (s.listener) begin
                        next_s.remote = 1'b0;
                     end
                  end else if (cmd == `CMD_SPE) begin
                     next_s.spoll = 1'b1;
                  end else if (cmd == `CMD_SPD) begin
                     next_s.spoll = 1'b0;
                  end else if (cmd == `CMD_PPC || cmd == `CMD_PPU) begin
                     next_s.spoll = s.spoll;
                  end
               end else begin
                  next_s.bus_rx_valid = 1'b1;
                  next_s.bus_rx_data = i_bus.dio;
                  next_s.bus_rx_eoi = i_bus.eoi;
               end
            end
         end
         AH_GOT: begin
            next_s.ah = AH_WAIT;
         end
         AH_WAIT: begin
            if (!i_bus.dav) begin
               next_s.ah = AH_RDY;
            end
         end
         default: begin
            next_s.ah = AH_RDY;
         end
      endcase

      // ---- source handshake for talker data and poll status
      case (s.sh)
         SH_IDLE: begin
            if (s.talker && !i_bus.atn) begin
               if (s.spoll) begin
                  next_s.sh = SH_WAIT;
                  next_s.sh_sp = 1'b1;
                  next_s.out.dio = {i_stb[7], s.out.srq_oe, i_stb[5:0]};
                  next_s.out.eoi_oe = 1'b1;
                  next_s.sh_cnt = 7'(`T1_CYC);
               end else if (i_bus_tx_valid) begin
                  next_s.sh = SH_WAIT;
                  next_s.sh_sp = 1'b0;
                  next_s.bus_tx_ready = 1'b1;
                  next_s.out.dio = i_bus_tx_data;
                  next_s.out.eoi_oe = i_bus_tx_eoi;
                  next_s.sh_cnt = 7'(`T1_CYC);
               end
            end
         end
         SH_WAIT: begin
            // data settles on the lines before the valid strobe
            if (s.sh_cnt != 7'h00) begin
               next_s.sh_cnt = s.sh_cnt - 7'h01;
            end else if (!i_bus.nrfd) begin
               next_s.sh = SH_DAV;
            end
         end
         SH_DAV: begin
            if (!i_bus.ndac) begin
               next_s.sh = SH_END;
               if (s.sh_sp && s.out.srq_oe) begin
                  next_s.rqs_sent = 1'b1;
               end
            end
         end
         default: begin
            next_s.sh = SH_IDLE;
         end
      endcase
      if (i_bus.atn || !s.talker) begin
         next_s.sh = SH_IDLE;
      end

      // ---- remote/local, clear and service request
      if (i_rtl && !s.lockout) begin
         next_s.remote = 1'b0;
      end
      if (!i_bus.ren) begin
         next_s.remote = 1'b0;
         next_s.lockout = 1'b0;
      end
      if (!i_srq_req) begin
         next_s.rqs_sent = 1'b0;
      end
      if (i_bus.ifc) begin
         next_s.talker = 1'b0;
         next_s.listener = 1'b0;
         next_s.spoll = 1'b0;
         next_s.sh = SH_IDLE;
      end
      if (next_s.dev_clear) begin
         next_s.sh = SH_IDLE;
      end

      // ---- registered bus drivers, open drain lines pull true
      next_s.out.dio_oe = next_s.sh != SH_IDLE;
      next_s.out.dav = 1'b1;
      next_s.out.dav_oe = next_s.sh == SH_DAV;
      next_s.out.eoi = 1'b1;
      next_s.out.eoi_oe = next_s.out.eoi_oe && next_s.out.dio_oe;
      next_s.out.nrfd = 1'b1;
      next_s.out.nrfd_oe = act && next_s.ah != AH_RDY;
      next_s.out.ndac = 1'b1;
      next_s.out.ndac_oe = act && next_s.ah != AH_WAIT;
      next_s.out.srq = 1'b1;
      next_s.out.srq_oe = i_srq_req && !next_s.rqs_sent;
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s <= '0;
      end else if (i_ce) begin
         s <= next_s;
      end
   end

   assign o_tx_ready = s.tx_ready;
   assign o_rx_valid = s.rx_valid;
   assign o_rx_data = s.rx_data;
   assign o_tx_held = s.tx_held;
   assign o_host_paused = s.host_paused;
   assign o_bus = s.out;
   assign o_bus_tx_ready = s.bus_tx_ready;
   assign o_bus_rx_valid = s.bus_rx_valid;
   assign o_bus_rx_data = s.bus_rx_data;
   assign o_bus_rx_eoi = s.bus_rx_eoi;
   assign o_talker = s.talker;
   assign o_listener = s.listener;
   assign o_spoll = s.spoll;
   assign o_remote = s.remote;
   assign o_lockout = s.lockout;
   assign o_dev_clear = s.dev_clear;
   assign o_trigger = s.trigger;

   // ==========================================
   // checks
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);

   sequence seq_cmd(logic [6:0] c);
      i_ce && s.ah == AH_RDY && i_bus.dav && i_bus.atn && !i_bus.ifc && cmd == c;
   endsequence
   sequence seq_rx(logic [7:0] c);
      i_ce && i_flow_en && u_rx_valid && u_rx_data == c;
   endsequence

   chk_xoff_sent: assert property (
      i_ce && i_flow_en && !s.host_paused && i_rx_level > `XOFF_LVL
      |=> s.host_paused && (s.pend_xoff || (s.u_start && s.u_data == `CHAR_XOFF)))
      else $error("stop code not scheduled at high level");
   chk_xon_sent: assert property (
      i_ce && i_flow_en && s.host_paused && i_rx_level < `XON_LVL
      |=> !s.host_paused && s.pend_xon)
      else $error("resume code not scheduled at low level");
   chk_tx_halt: assert property (seq_rx(`CHAR_XOFF) |=> s.tx_held && !s.rx_valid)
      else $error("stop code did not halt output");
   chk_tx_resume: assert property (seq_rx(`CHAR_XON) |=> !s.tx_held)
      else $error("resume code did not restart output");
   chk_held_quiet: assert property (
      s.tx_held |-> !o_tx_ready ##1 (!i_ce || !s.u_start || s.u_data != $past(i_tx_data)
      || !$past(i_tx_valid) || $past(s.tx_ready)))
      else $error("data accepted while held");
   chk_flow_off: assert property (i_ce && !i_flow_en |=> !s.tx_held && !s.host_paused)
      else $error("flow codes acted on while off");
   chk_mta_unlisten: assert property (
      seq_cmd({`GRP_TAG, i_my_addr}) |=> s.talker && !s.listener)
      else $error("own talk address left listener set");
   chk_mla_untalk: assert property (
      seq_cmd({`GRP_LAG, i_my_addr}) |=> s.listener && !s.talker)
      else $error("own listen address left talker set");
   chk_get_trigger: assert property (
      seq_cmd(`CMD_GET) |=> s.trigger == $past(s.listener) ##1 (!i_ce || !s.trigger))
      else $error("trigger pulse wrong");
   chk_dio_talker: assert property (s.out.dio_oe |-> $past(s.talker) || !$past(i_ce))
      else $error("data lines driven while not talker");
endmodule

/* tb/hlf_host_model.sv */
// Purpose: host computer on the serial line of the link block
// Assumes: bit period of P_DIV clocks, 8N1 framing
// Notes: the line rests high between frames; received bytes go to rx_q
`timescale 1ns/100ps
module hlf_host_model #(
   parameter int P_DIV = 16
) (
   input wire logic i_clock,
   input wire logic i_txd,
   output logic o_rxd
);
   logic [7:0] rx_q[$];
   logic [7:0] rx_b;
   initial o_rxd = 1'b1;
   // ==========================================
   // send one character, start bit first, then lsb first
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge i_clock);
         o_rxd = fr[i];
         repeat (P_DIV - 1) @(negedge i_clock);
      end
   endtask
   // ==========================================
   // receive mid-bit; a bad stop bit drops the character
   always begin
      @(negedge i_txd);
      repeat (P_DIV / 2) @(posedge i_clock);
      if (i_txd === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (P_DIV) @(posedge i_clock);
            rx_b[i] = i_txd;
         end
         repeat (P_DIV) @(posedge i_clock);
         if (i_txd === 1'b1) rx_q.push_back(rx_b);
      end
   end
endmodule

/* tb/hlf_link_tb.sv */
// Purpose: self-checking bench of the host link block
// Assumes: 9600 rate shortened to 16 clocks a bit
// Notes: the bench plays the bus controller; the host model plays the serial host
`timescale 1ns/100ps
module hlf_link_tb import hlf_pkg::*;;
   localparam int DIV = 16;
   logic i_clock, i_reset_n, i_rxd, o_txd, i_flow_en, i_tx_valid, o_tx_ready;
   logic o_rx_valid, o_tx_held, o_host_paused, i_srq_req, i_rtl, i_bus_tx_valid;
   logic i_bus_tx_eoi, o_bus_tx_ready, o_bus_rx_valid, o_bus_rx_eoi, o_talker;
   logic o_listener, o_spoll, o_remote, o_lockout, o_dev_clear, o_trigger;
   logic [8:0] i_rx_level, v;
   logic [7:0] i_tx_data, o_rx_data, i_stb, i_bus_tx_data, o_bus_rx_data, c_dio;
   logic c_dav, c_nrfd, c_ndac, c_atn, c_eoi, c_ren, i_ce;
   hlf_bus_in_t i_bus;
   hlf_bus_out_t o_bus;
   int num_errors = 0, check_count = 0, n_rx = 0, n_brx = 0, n_trig = 0, n_clr = 0, n_btx = 0;
   // ==========================================
   // open-drain wires: true when any party pulls
   assign i_bus = '{dio: c_dio | (o_bus.dio_oe ? o_bus.dio : 8'h00),
      dav: c_dav | (o_bus.dav_oe & o_bus.dav), nrfd: c_nrfd | (o_bus.nrfd_oe & o_bus.nrfd),
      ndac: c_ndac | (o_bus.ndac_oe & o_bus.ndac), atn: c_atn,
      eoi: c_eoi | (o_bus.eoi_oe & o_bus.eoi), ifc: 1'b0, ren: c_ren};
   hlf_link #(.P_DIV_9600(DIV)) u_hlf_link (.i_clock, .i_reset_n, .i_ce, .i_rxd, .o_txd,
      .i_baud(BAUD_9600), .i_flow_en, .i_rx_level, .i_tx_valid, .i_tx_data, .o_tx_ready,
      .o_rx_valid, .o_rx_data, .o_tx_held, .o_host_paused, .i_my_addr(5'h05), .i_bus, .o_bus,
      .i_stb, .i_srq_req, .i_rtl, .i_bus_tx_valid, .i_bus_tx_data, .i_bus_tx_eoi,
      .o_bus_tx_ready, .o_bus_rx_valid, .o_bus_rx_data, .o_bus_rx_eoi, .o_talker, .o_listener,
      .o_spoll, .o_remote, .o_lockout, .o_dev_clear, .o_trigger);
   hlf_host_model #(.P_DIV(DIV)) u_hlf_host_model (.i_clock, .i_txd(o_txd), .o_rxd(i_rxd));
   initial i_clock = 1'b0;
   always #12.5 i_clock = ~i_clock;
   // pulses last one cycle, so they are counted as they pass
   always @(posedge i_clock) begin
      n_rx += int'(o_rx_valid === 1'b1);
      n_brx += int'(o_bus_rx_valid === 1'b1);
      n_trig += int'(o_trigger === 1'b1);
      n_clr += int'(o_dev_clear === 1'b1);
      n_btx += int'(o_bus_tx_ready === 1'b1);
   end
   // ==========================================
   // shared tasks
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   task automatic expect_host(input logic [7:0] b);
      logic [8:0] got;
      got = 9'h100;
      for (int n = 0; n < 1000 && u_hlf_host_model.rx_q.size() == 0; n++) wait_clk(1);
      if (u_hlf_host_model.rx_q.size() > 0) got = {1'b0, u_hlf_host_model.rx_q.pop_front()};
      check("host got", got, {1'b0, b});
   endtask
   // ready is looked at on the falling edge, so the rising edge after it takes the byte
   task automatic serial_put(input logic [7:0] b);
      @(negedge i_clock);
      {i_tx_valid, i_tx_data} = {1'b1, b};
      for (int n = 0; n < 2000 && o_tx_ready !== 1'b1; n++) wait_clk(1);
      wait_clk(1);
      i_tx_valid = 1'b0;
   endtask
   // controller as source: dav held until the acceptor releases ndac
   task automatic bus_put(input logic atn, input logic [7:0] b);
      @(negedge i_clock);
      {c_atn, c_dio, c_nrfd, c_ndac} = {atn, b, 2'b00};
      wait_clk(2);
      for (int n = 0; n < 200 && i_bus.nrfd !== 1'b0; n++) wait_clk(1);
      c_dav = 1'b1;
      wait_clk(3);
      for (int n = 0; n < 200 && i_bus.ndac !== 1'b0; n++) wait_clk(1);
      {c_dav, c_dio} = 9'h000;
      wait_clk(4);
   endtask
   // controller as acceptor; nrfd stays true afterwards so no second byte starts
   task automatic bus_get(input logic send, input logic [7:0] d, output logic [8:0] got);
      @(negedge i_clock);
      {c_atn, c_nrfd, c_ndac} = 3'b001;
      {i_bus_tx_valid, i_bus_tx_data, i_bus_tx_eoi} = {send, d, 1'b1};
      for (int n = 0; n < 400 && i_bus.dav !== 1'b1; n++) wait_clk(1);
      got = {i_bus.eoi, i_bus.dio};
      {i_bus_tx_valid, c_ndac, c_nrfd} = 3'b001;
      for (int n = 0; n < 200 && i_bus.dav !== 1'b0; n++) wait_clk(1);
      wait_clk(2);
   endtask
   // ==========================================
   // watchdog: the whole run needs well under 20000 clocks
   initial begin
      repeat (60000) @(posedge i_clock);
      num_errors++;
      end_of_test();
   end
   // ==========================================
   // test sequence
   initial begin
      i_reset_n = 1'b0;
      {i_ce, i_flow_en, i_tx_valid, i_tx_data, i_rx_level} = {2'b11, 18'h00000};
      {i_stb, i_srq_req, i_rtl, i_bus_tx_valid, i_bus_tx_data, i_bus_tx_eoi} = '0;
      {c_dio, c_dav, c_nrfd, c_ndac, c_atn, c_eoi, c_ren} = '0;
      wait_clk(10);
      i_reset_n = 1'b1;
      wait_clk(4);
      // thresholds are strict, so the boundary levels must stay quiet
      i_rx_level = 9'h0C0;
      wait_clk(300);
      check("paused", o_host_paused, 9'h000);
      i_rx_level = 9'h0C1;
      expect_host(8'h13);
      check("paused", o_host_paused, 9'h001);
      i_rx_level = 9'h040;
      wait_clk(300);
      check("queue", 9'(u_hlf_host_model.rx_q.size()), 9'h000);
      i_rx_level = 9'h03F;
      expect_host(8'h11);
      check("paused", o_host_paused, 9'h000);
      $display("test flow toward host done");
      u_hlf_host_model.send_byte(8'h13);
      wait_clk(40);
      check("held", o_tx_held, 9'h001);
      fork
         serial_put(8'h5A);
      join_none
      wait_clk(500);
      check("queue", 9'(u_hlf_host_model.rx_q.size()), 9'h000);
      u_hlf_host_model.send_byte(8'h11);
      expect_host(8'h5A);
      check("held", o_tx_held, 9'h000);
      u_hlf_host_model.send_byte(8'hA5);
      wait_clk(40);
      check("rx data", {1'b0, o_rx_data}, 9'h0A5);
      check("rx pulses", 9'(n_rx), 9'h001);
      $display("test host pause done");
      i_flow_en = 1'b0;
      i_rx_level = 9'h0C8;
      wait_clk(300);
      check("paused", o_host_paused, 9'h000);
      u_hlf_host_model.send_byte(8'h13);
      wait_clk(40);
      check("held", o_tx_held, 9'h000);
      check("rx data", {1'b0, o_rx_data}, 9'h013);
      check("queue", 9'(u_hlf_host_model.rx_q.size()), 9'h000);
      i_rx_level = 9'h000;
      wait_clk(4);
      i_flow_en = 1'b1;
      $display("test flow off done");
      c_ren = 1'b1;
      bus_put(1'b1, 8'h25);
      check("listener", o_listener, 9'h001);
      check("remote", o_remote, 9'h001);
      bus_put(1'b0, 8'h4B);
      check("bus data", {o_bus_rx_eoi, o_bus_rx_data}, 9'h04B);
      check("bus pulses", 9'(n_brx), 9'h001);
      bus_put(1'b1, 8'h08);
      check("trigger", 9'(n_trig), 9'h001);
      bus_put(1'b1, 8'h14);
      check("clear", 9'(n_clr), 9'h001);
      bus_put(1'b1, 8'h11);
      i_rtl = 1'b1;
      wait_clk(4);
      check("lockout", {o_lockout, o_remote}, 9'h003);
      i_rtl = 1'b0;
      bus_put(1'b1, 8'h45);
      check("roles", {o_talker, o_listener}, 9'h002);
      bus_get(1'b1, 8'h4F, v);
      check("talk data", v, 9'h14F);
      check("taken", 9'(n_btx), 9'h001);
      bus_put(1'b1, 8'h25);
      check("roles", {o_talker, o_listener}, 9'h001);
      $display("test bus addressing done");
      {i_srq_req, i_stb} = 9'h121;
      wait_clk(4);
      check("srq", o_bus.srq_oe, 9'h001);
      bus_put(1'b1, 8'h18);
      bus_put(1'b1, 8'h45);
      bus_get(1'b0, 8'h00, v);
      check("status", v, 9'h161);
      check("spoll", o_spoll, 9'h001);
      wait_clk(4);
      check("srq", o_bus.srq_oe, 9'h000);
      bus_put(1'b1, 8'h19);
      i_srq_req = 1'b0;
      bus_put(1'b1, 8'h3F);
      bus_put(1'b0, 8'h77);
      check("bus pulses", 9'(n_brx), 9'h001);
      {c_atn, c_eoi} = 2'b11;
      wait_clk(10);
      check("no poll", o_bus.dio_oe, 9'h000);
      // with the enable low, dropping remote enable must not reach the state yet
      {c_atn, c_eoi, c_ren, i_ce} = 4'h8;
      wait_clk(4);
      check("frozen", {o_remote, o_lockout}, 9'h003);
      i_ce = 1'b1;
      wait_clk(4);
      check("local", {o_remote, o_lockout}, 9'h000);
      $display("test serial poll done");
      end_of_test();
   end
endmodule
